// ==== srt_ctrl_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module srt_checker (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic reset_n_in,
	// watched ports
	input wire logic cmd_valid_in,
	input wire logic [7:0] cmd_code_in,
	input wire logic store_all_in,
	input wire logic clear_faults_in,
	input wire logic rsp_valid_out,
	input wire logic rsp_nack_out,
	input wire logic [15:0] rsp_rdata_out,
	input wire logic nvm_store_out,
	input wire logic invalid_command_flag_out,
	input wire logic startup_timeout_fault_out,
	input wire logic smbalert_out,
	input wire logic restart_start_out,
	input wire logic [6:0] effective_ramp_ms_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!reset_n_in);
	logic ours;
	assign ours = cmd_valid_in && (cmd_code_in == 8'h61 || cmd_code_in == 8'h62);
	a_answer_next: assert property (ours |=> rsp_valid_out) else $error("no answer");
	a_foreign_quiet: assert property (cmd_valid_in && !ours |=> !rsp_valid_out) else $error("foreign answer");
	a_upper_zero: assert property (rsp_valid_out |-> rsp_rdata_out[15:7] == 9'h000) else $error("upper bits");
	a_nack_flags: assert property (rsp_valid_out && rsp_nack_out |-> invalid_command_flag_out && smbalert_out)
		else $error("nack without flags");
	a_flag_sticky: assert property (invalid_command_flag_out && !clear_faults_in |=> invalid_command_flag_out)
		else $error("flag lost");
	a_fault_alert: assert property ($rose(startup_timeout_fault_out) |-> smbalert_out) else $error("fault no alert");
	a_fault_sticky: assert property (startup_timeout_fault_out && !clear_faults_in |=> startup_timeout_fault_out)
		else $error("fault lost");
	a_store_pulse: assert property (store_all_in |=> nvm_store_out) else $error("no store");
	a_restart_single: assert property (restart_start_out |=> !restart_start_out) else $error("restart long");
	a_ramp_bucket: assert property (effective_ramp_ms_out inside {[7'h01:7'h07], 7'h0A, 7'h0E, 7'h13, 7'h1B,
		7'h25, 7'h34, 7'h48, 7'h64}) else $error("ramp off table");
endmodule : srt_checker
bind srt_startup_ramp_timeout_ctrl srt_checker i_chk (.ref_clk_in, .reset_n_in, .cmd_valid_in, .cmd_code_in,
	.store_all_in, .clear_faults_in, .rsp_valid_out, .rsp_nack_out, .rsp_rdata_out, .nvm_store_out,
	.invalid_command_flag_out, .startup_timeout_fault_out, .smbalert_out, .restart_start_out,
	.effective_ramp_ms_out);
`default_nettype wire

// ==== srt_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module srt_host (
	// clock
	input wire logic ref_clk_in,
	// command side
	output logic cmd_valid_out,
	output logic cmd_write_out,
	output logic [7:0] cmd_code_out,
	output logic [15:0] cmd_wdata_out,
	// answer side
	input wire logic rsp_valid_in,
	input wire logic rsp_nack_in,
	input wire logic [15:0] rsp_rdata_in
);
	initial begin
		cmd_valid_out = 1'b0;
		cmd_write_out = 1'b0;
		cmd_code_out = 8'h00;
		cmd_wdata_out = 16'h0000;
	end
	task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data,
		output logic got, output logic nack, output logic [15:0] rd);
		@(posedge ref_clk_in);
		cmd_valid_out <= 1'b1;
		cmd_write_out <= wr;
		cmd_code_out <= code;
		cmd_wdata_out <= data;
		@(posedge ref_clk_in);
		cmd_valid_out <= 1'b0;
		// stale word is not left on the lines
		cmd_wdata_out <= ~data;
		#1;
		got = rsp_valid_in;
		nack = rsp_nack_in;
		rd = rsp_rdata_in;
	endtask : xfer
endmodule : srt_host
`default_nettype wire

// ==== srt_map.svh ====
`ifndef SRT_MAP_SVH
`define SRT_MAP_SVH
// ----------------------------------------
// command codes
// ----------------------------------------
`define SRT_CODE_RAMP 8'h61
`define SRT_CODE_TMO 8'h62
// ----------------------------------------
// word layout and reset values
// ----------------------------------------
`define SRT_EXP_MSB 15
`define SRT_EXP_LSB 11
`define SRT_MANT_MSB 6
`define SRT_MANT_LSB 0
`define SRT_RAMP_RESET 7'h03
`define SRT_TMO_RESET 7'h00
// ----------------------------------------
// timing
// ----------------------------------------
`define SRT_CLK_PERIOD_NS 8
`define SRT_TICK_NS 1000000
`define SRT_TICK_CYCLES (`SRT_TICK_NS / `SRT_CLK_PERIOD_NS)
`define SRT_SLAVE_RAMP_MS 7'h64
`define SRT_GRACE_MS 13'h0FA0
`define SRT_RETRY_TIMES 13'h0007
`endif

// ==== srt_ms_tick.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "srt_map.svh"
module srt_ms_tick #(
	parameter int unsigned TICK_CYCLES = `SRT_TICK_CYCLES
) (
	input wire logic ref_clk_in,
	input wire logic reset_n_in,
	input wire logic align_in,
	output logic tick_out
);
	logic [31:0] count;
	logic [31:0] next_count;
	logic next_tick;

	// realigned on start so the first tick lands one full millisecond later
	always_comb begin
		next_tick = 1'b0;
		next_count = count + 32'h00000001;
		if (align_in) begin
			next_count = 32'h00000000;
		end else if (count >= TICK_CYCLES - 1) begin
			next_count = 32'h00000000;
			next_tick = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			count <= 32'h00000000;
			tick_out <= 1'b0;
		end else begin
			count <= next_count;
			tick_out <= next_tick;
		end
	end
endmodule : srt_ms_tick
`default_nettype wire

// ==== srt_pkg.sv ====
`include "srt_map.svh"
package srt_pkg;
	typedef logic [6:0] srt_mant_t;
	typedef logic [12:0] srt_ms_t;
	typedef enum logic [2:0] {
		SRT_IDLE = 3'b001,
		SRT_RUN = 3'b010,
		SRT_RETRY = 3'b100
	} srt_state_t;

	// bucket table shared by both timing words; zero maps to zero_ms
	function automatic srt_mant_t srt_quantize(input srt_mant_t m, input srt_mant_t zero_ms);
		srt_mant_t r;
		r = 7'h64;
		if (m == 7'h00) r = zero_ms;
		else if (m <= 7'h06) r = m;
		else if (m <= 7'h09) r = 7'h07;
		else if (m <= 7'h0C) r = 7'h0A;
		else if (m <= 7'h11) r = 7'h0E;
		else if (m <= 7'h16) r = 7'h13;
		else if (m <= 7'h20) r = 7'h1B;
		else if (m <= 7'h2C) r = 7'h25;
		else if (m <= 7'h3E) r = 7'h34;
		else if (m <= 7'h56) r = 7'h48;
		return r;
	endfunction : srt_quantize
endpackage : srt_pkg

// ==== srt_startup_ramp_timeout_ctrl.sv ====
// How it works
// RL1: command 61h holds the ramp time in milliseconds, reference rise to regulation.
// RL2: save-all-defaults copies the ramp setting out to nonvolatile storage.
// RL3: loop slave: both commands NACKed, writes ignored, invalid-command flag and alert raised.
// RL4: a programmed ramp of zero runs as a one millisecond ramp.
// RL5: both words are linear format, exponent read-only zero, one millisecond steps.
// RL6: ramp mantissa upper four bits read zero, lower seven writable, reset three.
// RL7: a loop slave always ramps in 100 milliseconds.
// RL8: ramp mantissa is rounded up into fixed buckets, above 86 gives 100; the code rounds 8-9, 11-12, 15-17, 20-22, 28-32, 38-44, 53-62 and 73-86 down.
// RL9: command 62h bounds startup time; timer starts when the ramp begins.
// RL10: a timeout limit of zero disables the timer; the code checks it at start only, a later zero gets the RL11 deadline.
// RL11: limit below ramp faults four seconds after the ramp ends instead.
// RL12: timeout limit has no storage; restore-all-defaults sets it to zero.
// RL13: timeout exponent zero, upper four mantissa bits zero, reset disables timer.
// RL14: timeout mantissa uses the same buckets, with zero meaning disabled.
// RL15: a startup timeout sets the fault flag and raises the alert.
// RL16: with restart enabled, wait seven ramp times after a fault, then restart.
// RL17: timer counts millisecond ticks, clears on reaching undervoltage level or turn-off.
`timescale 1ns/1ps
`default_nettype none
`include "srt_map.svh"
module srt_startup_ramp_timeout_ctrl #(
	parameter int unsigned TICK_CYCLES = `SRT_TICK_CYCLES
) (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic reset_n_in,
	// command port
	input wire logic cmd_valid_in,
	input wire logic cmd_write_in,
	input wire logic [7:0] cmd_code_in,
	input wire logic [15:0] cmd_wdata_in,
	output logic rsp_valid_out,
	output logic rsp_nack_out,
	output logic [15:0] rsp_rdata_out,
	// default storage
	input wire logic store_all_in,
	input wire logic restore_all_in,
	input wire logic [6:0] nvm_ramp_in,
	output logic nvm_store_out,
	output logic [6:0] nvm_ramp_out,
	// status
	input wire logic clear_faults_in,
	output logic invalid_command_flag_out,
	output logic startup_timeout_fault_out,
	output logic smbalert_out,
	// power sequencing
	input wire logic loop_slave_in,
	input wire logic output_above_uv_in,
	input wire logic converter_on_in,
	input wire logic ramp_begin_in,
	input wire logic restart_enable_in,
	output logic restart_start_out,
	output logic [6:0] effective_ramp_ms_out
);
	// ----------------------------------------
	// local functions
	// ----------------------------------------
	// command codes only count while a command is presented
	function automatic logic cmd_hit(input logic valid, input logic [7:0] code, input logic [7:0] want);
		return valid && (code == want);
	endfunction : cmd_hit

	// exponent and upper mantissa bits always read as zero
	function automatic logic [15:0] linear_word(input srt_pkg::srt_mant_t mant);
		return {5'h00, 4'h0, mant};
	endfunction : linear_word

	// only the low mantissa bits take a write; the rest are dropped
	function automatic srt_pkg::srt_mant_t writable_mant(input logic [15:0] word);
		return word[`SRT_MANT_MSB:`SRT_MANT_LSB];
	endfunction : writable_mant

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [1:0] sync1;
	logic [1:0] sync2;
	logic [1:0] sync3;
	logic [1:0] pin_level;
	logic [1:0] next_pin_level;
	logic loop_slave;
	logic above_uv;

	// a pin change is accepted only once the second and third stages agree
	always_comb begin
		next_pin_level = pin_level;
		for (int i = 0; i < 2; i++) begin
			if (sync2[i] == sync3[i]) begin
				next_pin_level[i] = sync3[i];
			end
		end
	end

	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sync1 <= 2'h0;
			sync2 <= 2'h0;
			sync3 <= 2'h0;
			pin_level <= 2'h0;
		end else begin
			sync1 <= {output_above_uv_in, loop_slave_in};
			sync2 <= sync1;
			sync3 <= sync2;
			pin_level <= next_pin_level;
		end
	end

	// bit 0 carries the loop slave pin, bit 1 the undervoltage compare
	assign loop_slave = pin_level[0];
	assign above_uv = pin_level[1];

	// ----------------------------------------
	// settings and command handling
	// ----------------------------------------
	srt_pkg::srt_mant_t ramp_mant;
	srt_pkg::srt_mant_t next_ramp_mant;
	srt_pkg::srt_mant_t tmo_mant;
	srt_pkg::srt_mant_t next_tmo_mant;
	logic next_rsp_valid;
	logic next_rsp_nack;
	logic [15:0] next_rsp_rdata;
	logic next_nvm_store;
	logic [6:0] next_nvm_ramp;
	logic hit_ramp;
	logic hit_tmo;
	logic refused;

	always_comb begin
		hit_ramp = cmd_hit(cmd_valid_in, cmd_code_in, `SRT_CODE_RAMP); // RL1
		hit_tmo = cmd_hit(cmd_valid_in, cmd_code_in, `SRT_CODE_TMO); // RL9
		// a refused command still answers, carrying the nack
		refused = (hit_ramp || hit_tmo) && loop_slave; // RL3
		next_ramp_mant = ramp_mant;
		next_tmo_mant = tmo_mant;
		next_rsp_valid = hit_ramp || hit_tmo;
		next_rsp_nack = refused; // RL3
		next_rsp_rdata = 16'h0000;
		next_nvm_store = 1'b0;
		next_nvm_ramp = nvm_ramp_out;
		// restore first, so a write in the same cycle wins
		if (restore_all_in) begin
			next_ramp_mant = nvm_ramp_in;
			next_tmo_mant = `SRT_TMO_RESET; // RL12
		end
		if (hit_ramp && !refused) begin
			if (cmd_write_in) begin
				// exponent and upper mantissa bits are read-only zero
				next_ramp_mant = writable_mant(cmd_wdata_in); // RL6
			end else begin
				next_rsp_rdata = linear_word(ramp_mant); // RL5
			end
		end
		if (hit_tmo && !refused) begin
			if (cmd_write_in) begin
				// a zero limit here keeps the timer from starting; a running timer gets ramp plus grace
				next_tmo_mant = writable_mant(cmd_wdata_in); // RL13
			end else begin
				next_rsp_rdata = linear_word(tmo_mant); // RL5
			end
		end
		if (store_all_in) begin
			next_nvm_store = 1'b1; // RL2
			next_nvm_ramp = ramp_mant; // RL2
		end
	end

	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ramp_mant <= `SRT_RAMP_RESET; // RL6
			tmo_mant <= `SRT_TMO_RESET; // RL13
			rsp_valid_out <= 1'b0;
			rsp_nack_out <= 1'b0;
			rsp_rdata_out <= 16'h0000;
			nvm_store_out <= 1'b0;
			nvm_ramp_out <= 7'h00;
		end else begin
			ramp_mant <= next_ramp_mant;
			tmo_mant <= next_tmo_mant;
			rsp_valid_out <= next_rsp_valid;
			rsp_nack_out <= next_rsp_nack;
			rsp_rdata_out <= next_rsp_rdata;
			nvm_store_out <= next_nvm_store;
			nvm_ramp_out <= next_nvm_ramp;
		end
	end

	// ----------------------------------------
	// effective times
	// ----------------------------------------
	srt_pkg::srt_mant_t ramp_ms;
	srt_pkg::srt_mant_t limit_ms;
	srt_pkg::srt_mant_t next_eff_ramp;

	always_comb begin
		// a loop slave ignores the programmed ramp
		if (loop_slave) begin
			ramp_ms = `SRT_SLAVE_RAMP_MS; // RL7
		end else begin
			ramp_ms = srt_pkg::srt_quantize(ramp_mant, 7'h01); // RL4 RL8
		end
		limit_ms = srt_pkg::srt_quantize(tmo_mant, 7'h00); // RL14
		next_eff_ramp = ramp_ms;
	end

	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			effective_ramp_ms_out <= `SRT_RAMP_RESET;
		end else begin
			effective_ramp_ms_out <= next_eff_ramp;
		end
	end

	// ----------------------------------------
	// startup timeout timer
	// ----------------------------------------
	srt_timer_if tif ();
	logic tick;

	assign tif.ramp_ms = ramp_ms;
	assign tif.limit_ms = limit_ms;
	assign tif.start = ramp_begin_in; // RL9
	// turn-off clears the timer from any state
	assign tif.stop = !converter_on_in; // RL17
	assign tif.above_uv = above_uv; // RL17
	assign tif.restart_en = restart_enable_in; // RL16

	// the tick restarts on a fault so the retry wait counts whole milliseconds
	srt_ms_tick #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_tick (
		.ref_clk_in(ref_clk_in),
		.reset_n_in(reset_n_in),
		.align_in(ramp_begin_in || tif.fault),
		.tick_out(tick)
	);

	srt_startup_timer u_timer (
		.ref_clk_in(ref_clk_in),
		.reset_n_in(reset_n_in),
		.tick_in(tick),
		.tif(tif)
	);

	// ----------------------------------------
	// restart request
	// ----------------------------------------
	logic next_restart;

	// a single-cycle strobe, kept apart from the sticky flags; turn-off cancels it
	always_comb begin
		next_restart = tif.restart && converter_on_in; // RL16
	end

	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			restart_start_out <= 1'b0;
		end else begin
			restart_start_out <= next_restart;
		end
	end

	// ----------------------------------------
	// status flags and alert
	// ----------------------------------------
	logic next_ivc;
	logic next_tmo_fault;
	logic next_alert;

	// a new event in the clearing cycle wins over the clear
	always_comb begin
		next_ivc = invalid_command_flag_out;
		next_tmo_fault = startup_timeout_fault_out;
		next_alert = smbalert_out;
		if (clear_faults_in) begin
			next_ivc = 1'b0;
			next_tmo_fault = 1'b0;
			next_alert = 1'b0;
		end
		if (refused) begin
			next_ivc = 1'b1; // RL3
			next_alert = 1'b1; // RL3
		end
		if (tif.fault) begin
			next_tmo_fault = 1'b1; // RL15
			next_alert = 1'b1; // RL15
		end
	end

	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			invalid_command_flag_out <= 1'b0;
			startup_timeout_fault_out <= 1'b0;
			smbalert_out <= 1'b0;
		end else begin
			invalid_command_flag_out <= next_ivc;
			startup_timeout_fault_out <= next_tmo_fault;
			smbalert_out <= next_alert;
		end
	end
endmodule : srt_startup_ramp_timeout_ctrl
`default_nettype wire

// ==== srt_startup_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "srt_map.svh"
module srt_startup_timer (
	input wire logic ref_clk_in,
	input wire logic reset_n_in,
	input wire logic tick_in,
	srt_timer_if.timer tif
);
	srt_pkg::srt_state_t state;
	srt_pkg::srt_state_t next_state;
	srt_pkg::srt_ms_t elapsed;
	srt_pkg::srt_ms_t next_elapsed;
	srt_pkg::srt_ms_t deadline;
	srt_pkg::srt_ms_t retry_ms;
	logic next_fault;
	logic next_restart;

	// a limit below the ramp is stretched to ramp end plus the grace period
	always_comb begin
		if (tif.limit_ms < tif.ramp_ms) begin
			deadline = {6'h00, tif.ramp_ms} + `SRT_GRACE_MS; // RL11
		end else begin
			deadline = {6'h00, tif.limit_ms};
		end
		retry_ms = 13'(`SRT_RETRY_TIMES * {6'h00, tif.ramp_ms}); // RL16
	end

	always_comb begin
		next_state = state;
		next_elapsed = elapsed;
		next_fault = 1'b0;
		next_restart = 1'b0;
		case (state)
			srt_pkg::SRT_IDLE: begin
				if (tif.start && tif.limit_ms != 7'h00) begin // RL10
					next_state = srt_pkg::SRT_RUN; // RL9
					next_elapsed = 13'h0000;
				end
			end
			srt_pkg::SRT_RUN: begin
				if (tif.stop || tif.above_uv) begin
					next_state = srt_pkg::SRT_IDLE; // RL17
					next_elapsed = 13'h0000;
				end else if (tick_in) begin
					next_elapsed = elapsed + 13'h0001; // RL17
					if (elapsed + 13'h0001 >= deadline) begin
						next_fault = 1'b1;
						next_elapsed = 13'h0000;
						next_state = tif.restart_en ? srt_pkg::SRT_RETRY : srt_pkg::SRT_IDLE;
					end
				end
			end
			srt_pkg::SRT_RETRY: begin
				if (tif.stop) begin
					next_state = srt_pkg::SRT_IDLE;
					next_elapsed = 13'h0000;
				end else if (tick_in) begin
					next_elapsed = elapsed + 13'h0001;
					if (elapsed + 13'h0001 >= retry_ms) begin
						next_restart = 1'b1; // RL16
						next_elapsed = 13'h0000;
						next_state = srt_pkg::SRT_IDLE;
					end
				end
			end
			default: begin
				next_state = srt_pkg::SRT_IDLE;
				next_elapsed = 13'h0000;
			end
		endcase
	end

	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state <= srt_pkg::SRT_IDLE;
			elapsed <= 13'h0000;
			tif.fault <= 1'b0;
			tif.restart <= 1'b0;
		end else begin
			state <= next_state;
			elapsed <= next_elapsed;
			tif.fault <= next_fault;
			tif.restart <= next_restart;
		end
	end
endmodule : srt_startup_timer
`default_nettype wire

// ==== srt_timer_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface srt_timer_if;
	srt_pkg::srt_mant_t ramp_ms;
	srt_pkg::srt_mant_t limit_ms;
	logic start;
	logic stop;
	logic above_uv;
	logic restart_en;
	logic fault;
	logic restart;
	modport ctrl (output ramp_ms, output limit_ms, output start, output stop, output above_uv,
		output restart_en, input fault, input restart);
	modport timer (input ramp_ms, input limit_ms, input start, input stop, input above_uv,
		input restart_en, output fault, output restart);
endinterface : srt_timer_if
`default_nettype wire

// ==== test_startup_ramp_timeout_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_startup_ramp_timeout_ctrl;
	logic ref_clk_in, reset_n_in, valid, write, slave, above_uv, conv_on, rst_en;
	logic got, nack, rv, rn, nvst, flag, fault, alert, restart;
	logic [3:0] pls;
	logic [7:0] code;
	logic [15:0] wdata, rdata, rsp;
	logic [6:0] nvm_in, nvm_out, eff;
	int checks = 0;
	int num_errors = 0;
	logic [6:0] bin [13] = '{7'h00, 7'h06, 7'h07, 7'h09, 7'h0A, 7'h0D, 7'h16, 7'h17, 7'h2C, 7'h3E, 7'h3F, 7'h56, 7'h57};
	logic [6:0] bout [13] = '{7'h01, 7'h06, 7'h07, 7'h07, 7'h0A, 7'h0E, 7'h13, 7'h1B, 7'h25, 7'h34, 7'h48, 7'h48, 7'h64};
	srt_startup_ramp_timeout_ctrl #(.TICK_CYCLES(10)) i_dut (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
		.cmd_valid_in(valid), .cmd_write_in(write), .cmd_code_in(code), .cmd_wdata_in(wdata),
		.rsp_valid_out(rv), .rsp_nack_out(rn), .rsp_rdata_out(rsp), .store_all_in(pls[1]),
		.restore_all_in(pls[2]), .nvm_ramp_in(nvm_in), .nvm_store_out(nvst), .nvm_ramp_out(nvm_out),
		.clear_faults_in(pls[3]), .invalid_command_flag_out(flag), .startup_timeout_fault_out(fault),
		.smbalert_out(alert), .loop_slave_in(slave), .output_above_uv_in(above_uv), .converter_on_in(conv_on),
		.ramp_begin_in(pls[0]), .restart_enable_in(rst_en), .restart_start_out(restart),
		.effective_ramp_ms_out(eff));
	srt_host i_host (.ref_clk_in(ref_clk_in), .cmd_valid_out(valid), .cmd_write_out(write), .cmd_code_out(code),
		.cmd_wdata_out(wdata), .rsp_valid_in(rv), .rsp_nack_in(rn), .rsp_rdata_in(rsp));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input logic [15:0] g, input logic [15:0] e, input string what);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, g, e);
		end
	endtask : chk
	task automatic xf(input logic w, input logic [7:0] c, input logic [15:0] d, input logic [15:0] e, input logic en);
		i_host.xfer(w, c, d, got, nack, rdata);
		chk(16'(got), 16'h0001, "answer");
		chk(16'(nack), 16'(en), "nack");
		if (!w && !en) chk(rdata, e, "read word");
	endtask : xf
	task automatic pulse(input logic [3:0] m);
		@(posedge ref_clk_in);
		pls <= m;
		@(posedge ref_clk_in);
		pls <= 4'h0;
	endtask : pulse
	task automatic wait_on(input int sel, input int lim, output int n);
		n = 0;
		do begin
			@(posedge ref_clk_in);
			#1;
			n++;
		end while (n < lim && !(sel == 0 ? fault : sel == 1 ? restart : nvst));
	endtask : wait_on
	task automatic test_done;
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : test_done
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		xf(1'b0, 8'h61, 16'h0000, 16'h0003, 1'b0);
		xf(1'b0, 8'h62, 16'h0000, 16'h0000, 1'b0);
		chk(16'(eff), 16'h0003, "reset ramp");
		i_host.xfer(1'b0, 8'h60, 16'h0000, got, nack, rdata);
		chk(16'(got), 16'h0000, "foreign code");
		$display("reset test done");
	endtask : t_reset
	task automatic t_buckets;
		for (int i = 0; i < 13; i++) begin
			xf(1'b1, 8'h61, {9'h1FF, bin[i]}, 16'h0000, 1'b0);
			@(posedge ref_clk_in);
			#1;
			chk(16'(eff), 16'(bout[i]), "bucket");
			xf(1'b0, 8'h61, 16'h0000, {9'h000, bin[i]}, 1'b0);
			xf(1'b1, 8'h62, {9'h1FF, bin[i]}, 16'h0000, 1'b0);
			xf(1'b0, 8'h62, 16'h0000, {9'h000, bin[i]}, 1'b0);
		end
		$display("bucket test done");
	endtask : t_buckets
	task automatic t_store;
		xf(1'b1, 8'h61, 16'h0015, 16'h0000, 1'b0);
		xf(1'b1, 8'h62, 16'h0009, 16'h0000, 1'b0);
		pulse(4'h2);
		nvm_in <= 7'h2A;
		#1;
		chk(16'(nvst), 16'h0001, "store pulse");
		chk(16'(nvm_out), 16'h0015, "stored ramp");
		pulse(4'h4);
		xf(1'b0, 8'h61, 16'h0000, 16'h002A, 1'b0);
		xf(1'b0, 8'h62, 16'h0000, 16'h0000, 1'b0);
		$display("store test done");
	endtask : t_store
	task automatic t_timer(input logic [15:0] r, input logic [15:0] l, input int lo, input int hi);
		int n;
		xf(1'b1, 8'h61, r, 16'h0000, 1'b0);
		xf(1'b1, 8'h62, l, 16'h0000, 1'b0);
		pulse(4'h1);
		wait_on(0, hi + 10, n);
		chk(16'(n >= lo && n <= hi), 16'h0001, "fault time");
		chk(16'(alert), 16'h0001, "fault alert");
		wait_on(1, 400, n);
		chk(16'(n >= 7 * 10 * r - 6 && n <= 7 * 10 * r + 6), 16'h0001, "restart time");
		pulse(4'h8);
		#1;
		chk(16'({fault, alert}), 16'h0000, "cleared");
		$display("timer test done");
	endtask : t_timer
	task automatic t_quiet;
		xf(1'b1, 8'h62, 16'h0000, 16'h0000, 1'b0);
		pulse(4'h1);
		repeat (150) @(posedge ref_clk_in);
		#1;
		chk(16'(fault), 16'h0000, "disabled timer");
		xf(1'b1, 8'h62, 16'h0005, 16'h0000, 1'b0);
		pulse(4'h1);
		above_uv <= 1'b1;
		repeat (100) @(posedge ref_clk_in);
		above_uv <= 1'b0;
		#1;
		chk(16'(fault), 16'h0000, "stopped timer");
		repeat (8) @(posedge ref_clk_in);
		xf(1'b1, 8'h62, 16'h0005, 16'h0000, 1'b0);
		pulse(4'h1);
		conv_on <= 1'b0;
		repeat (100) @(posedge ref_clk_in);
		conv_on <= 1'b1;
		#1;
		chk(16'(fault), 16'h0000, "turned off timer");
		$display("quiet test done");
	endtask : t_quiet
	task automatic t_noretry;
		int n;
		xf(1'b1, 8'h62, 16'h0003, 16'h0000, 1'b0);
		pulse(4'h1);
		rst_en <= 1'b0;
		wait_on(0, 40, n);
		chk(16'(n >= 28 && n <= 36), 16'h0001, "fault time");
		wait_on(1, 300, n);
		chk(16'(restart), 16'h0000, "no restart");
		chk(16'({fault, alert}), 16'h0003, "fault flags");
		pulse(4'h8);
		rst_en <= 1'b1;
		$display("no retry test done");
	endtask : t_noretry
	task automatic t_slave;
		pulse(4'h8);
		slave <= 1'b1;
		repeat (8) @(posedge ref_clk_in);
		#1;
		chk(16'(eff), 16'h0064, "slave ramp");
		xf(1'b1, 8'h61, 16'h0050, 16'h0000, 1'b1);
		xf(1'b0, 8'h62, 16'h0000, 16'h0000, 1'b1);
		chk(16'({flag, alert}), 16'h0003, "slave flags");
		@(posedge ref_clk_in);
		slave <= 1'b0;
		repeat (8) @(posedge ref_clk_in);
		xf(1'b0, 8'h61, 16'h0000, 16'h0002, 1'b0);
		$display("slave test done");
	endtask : t_slave
	// ----------------------------------------
	// run
	// ----------------------------------------
	initial begin
		ref_clk_in = 1'b0;
		forever #4 ref_clk_in = ~ref_clk_in;
	end
	initial begin
		repeat (60000) @(posedge ref_clk_in);
		num_errors++;
		test_done();
	end
	initial begin
		{reset_n_in, slave, above_uv, pls, nvm_in} = '0;
		{conv_on, rst_en} = 2'b11;
		repeat (16) @(posedge ref_clk_in);
		reset_n_in <= 1'b1;
		t_reset();
		t_buckets();
		t_store();
		t_timer(16'h0003, 16'h0008, 66, 76);
		t_quiet();
		t_noretry();
		// limit below ramp: 2 ms ramp plus 4000 ms grace
		t_timer(16'h0002, 16'h0001, 40010, 40030);
		t_slave();
		test_done();
	end
endmodule : test_startup_ramp_timeout_ctrl
`default_nettype wire
